// ### verilog/cdh_defs.vh
// Constants for the character display host command interpreter
`ifndef CDH_DEFS_VH
`define CDH_DEFS_VH
// ==========================================================
// Instruction codes
`define CDH_CMD_CLEAR 8'h01
`define CDH_CMD_RETURN 8'h02
`define CDH_CMD_CURSOR_ON 8'h04
`define CDH_CMD_CURSOR_OFF 8'h05
`define CDH_SETPOS_BIT 7
`define CDH_LINE_BIT 6
// ==========================================================
// Busy timing at the reference oscillator (kHz, us)
`define CDH_REF_OSC_KHZ 200
`define CDH_CLK_KHZ 20000
`define CDH_BUSY_CLEAR_US 2000
`define CDH_BUSY_OTHER_US 50
// Cycles = us * clk_kHz / 1000, rounded up for least times
`define CDH_BUSY_CLEAR_CYC ((`CDH_BUSY_CLEAR_US * `CDH_CLK_KHZ + 999) / 1000)
`define CDH_BUSY_OTHER_CYC ((`CDH_BUSY_OTHER_US * `CDH_CLK_KHZ + 999) / 1000)
// ==========================================================
// Display memory
`define CDH_MAX_CHARS 80
`define CDH_BLANK_CODE 8'h20
`endif

// ### verilog/cdh_edge.v
// Strobe edge detector for the host port
module cdh_edge (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Strobe in, edges out
  input wire strobe,
  output wire rise,
  output wire fall
);
  reg last; // Strobe level one cycle ago

  // ==========================================================
  // Edge capture
  always @(posedge ref_clk) begin
    if (!nrst) begin
      last <= 1'b0;
    end else begin
      last <= strobe;
    end
  end

  assign rise = strobe & ~last;
  assign fall = ~strobe & last;
endmodule // cdh_edge

// ### verilog/cdh_top.v
// Host port and command interpreter of a character display controller
`include "cdh_defs.vh"

module cdh_top (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Host port
  input wire [3:0] device_select_lines,
  input wire register_select_line,
  input wire read_write,
  input wire strobe,
  input wire [7:0] host_data_lines,
  output wire busy_flag_line,
  output wire busy_flag_oe,
  // Static setup
  input wire [2:0] character_count_select,
  input wire line_count_select,
  input wire font_height_select,
  input wire cursor_shape_select,
  // Display state seen by the refresh logic
  input wire [6:0] view_addr,
  output reg [7:0] view_code,
  output reg [6:0] cursor_pos,
  output reg cursor_visible,
  output reg two_lines,
  output reg tall_font,
  output reg wide_cursor,
  output reg [6:0] char_total,
  output reg busy
);
  // ==========================================================
  // Declarations
  localparam ST_IDLE = 2'd0; // Waiting for a write
  localparam ST_HELD = 2'd1; // Data latched, waiting for strobe rise
  localparam ST_RUN = 2'd2; // Operation in progress
  localparam ST_WIPE = 2'd3; // Clear running, blanking memory
  localparam integer BUSY_OTHER = `CDH_BUSY_OTHER_CYC; // Clocks of busy for a plain operation
  localparam integer BUSY_CLEAR = `CDH_BUSY_CLEAR_CYC; // Clocks of busy for a clear
  localparam integer LAST_ADDR = `CDH_MAX_CHARS - 1; // Last character memory position
  localparam [7:0] CURSOR_PAIR = `CDH_CMD_CURSOR_ON; // On and off codes differ in bit 0 only

  reg [1:0] state; // Sequencer state
  reg [7:0] cmd_data; // Latched data byte
  reg cmd_is_char; // Latched register choice
  reg [16:0] busy_cnt; // Busy countdown
  reg [6:0] wipe_addr; // Blanking pointer
  reg [7:0] screen [0:`CDH_MAX_CHARS-1]; // Character memory
  reg [6:0] next_pos; // Cursor after a character write
  reg [6:0] half_total; // Characters per line in two-line mode
  wire selected; // All chip selects high
  wire st_rise; // Strobe rising edge
  wire st_fall; // Strobe falling edge

  assign selected = &device_select_lines;

  cdh_edge u_edge (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .strobe(strobe),
    .rise(st_rise),
    .fall(st_fall)
  );

  // ==========================================================
  // Busy flag read-back, combinational handshake output
  assign busy_flag_oe = selected & read_write & strobe;
  assign busy_flag_line = busy;

  // ==========================================================
  // Static setup decode, registered so outputs are defined at reset
  always @(posedge ref_clk) begin
    if (!nrst) begin
      char_total <= 7'd4;
      two_lines <= 1'b0;
      tall_font <= 1'b0;
      wide_cursor <= 1'b0;
    end else begin
      two_lines <= line_count_select;
      tall_font <= font_height_select;
      wide_cursor <= cursor_shape_select;
      case (character_count_select)
        3'd0: char_total <= 7'd4;
        3'd1: char_total <= 7'd8;
        3'd2: char_total <= 7'd16;
        3'd3: char_total <= 7'd24;
        3'd4: char_total <= 7'd32;
        3'd5: char_total <= 7'd40;
        3'd6: char_total <= 7'd64;
        default: char_total <= 7'd80;
      endcase
    end
  end

  // ==========================================================
  // Cursor advance with wrap at the configured count
  always @* begin
    half_total = {1'b0, char_total[6:1]};
    if (cursor_pos + 7'd1 >= char_total) begin
      next_pos = 7'd0; // Wrap keeps the cursor on the glass
    end else begin
      next_pos = cursor_pos + 7'd1;
    end
  end

  // ==========================================================
  // Sequencer: latch on fall, execute from rise, count busy
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cmd_data <= 8'h00;
      cmd_is_char <= 1'b0;
      busy_cnt <= 17'd0;
      wipe_addr <= 7'd0;
      cursor_pos <= 7'd0;
      cursor_visible <= 1'b1;
      busy <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // Writes during busy never reach here, so they are dropped
          if (st_fall && selected && !read_write) begin
            cmd_data <= host_data_lines;
            cmd_is_char <= register_select_line;
            state <= ST_HELD;
          end
        end
        ST_HELD: begin
          if (st_rise) begin
            busy <= 1'b1;
            busy_cnt <= BUSY_OTHER[16:0];
            state <= ST_RUN;
            if (cmd_is_char) begin
              cursor_pos <= next_pos;
            end else if (cmd_data[`CDH_SETPOS_BIT]) begin
              if (two_lines && cmd_data[`CDH_LINE_BIT]) begin
                cursor_pos <= half_total + {1'b0, cmd_data[5:0]};
              end else if (two_lines) begin
                cursor_pos <= {1'b0, cmd_data[5:0]};
              end else begin
                cursor_pos <= cmd_data[6:0];
              end
            end else if (cmd_data == `CDH_CMD_CLEAR) begin
              cursor_pos <= 7'd0;
              wipe_addr <= 7'd0;
              busy_cnt <= BUSY_CLEAR[16:0];
              state <= ST_WIPE;
            end else if (cmd_data == `CDH_CMD_RETURN) begin
              cursor_pos <= 7'd0;
            end else if (cmd_data[7:1] == CURSOR_PAIR[7:1]) begin
              cursor_visible <= ~cmd_data[0];
            end
          end else if (st_fall) begin
            // A second fall before the rise replaces the byte
            cmd_data <= host_data_lines;
            cmd_is_char <= register_select_line;
          end
        end
        ST_WIPE: begin
          // Blank every position while the clear time counts down
          busy_cnt <= busy_cnt - 17'd1;
          if (wipe_addr == LAST_ADDR[6:0]) begin
            state <= ST_RUN;
          end else begin
            wipe_addr <= wipe_addr + 7'd1;
          end
        end
        ST_RUN: begin
          if (busy_cnt <= 17'd1) begin
            busy <= 1'b0;
            state <= ST_IDLE;
          end else begin
            busy_cnt <= busy_cnt - 17'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Character memory: write on execute, blank during clear
  always @(posedge ref_clk) begin
    if (state == ST_WIPE) begin
      screen[wipe_addr] <= `CDH_BLANK_CODE;
    end else if (state == ST_HELD && st_rise && cmd_is_char) begin
      screen[cursor_pos] <= cmd_data;
    end
  end

  // ==========================================================
  // Registered read port for the refresh logic
  always @(posedge ref_clk) begin
    if (!nrst) begin
      view_code <= 8'h00;
    end else if (view_addr <= LAST_ADDR[6:0]) begin
      view_code <= screen[view_addr];
    end else begin
      view_code <= 8'h00; // Out-of-range addresses read zero
    end
  end
endmodule // cdh_top

// ### dv/cdh_mon_monitor.sv
// Assertion checker for the display host port
module cdh_mon (
  input wire logic ref_clk, nrst, register_select_line, read_write, strobe, busy_flag_line, busy_flag_oe,
  input wire logic line_count_select, font_height_select, cursor_shape_select, cursor_visible,
  input wire logic two_lines, tall_font, wide_cursor, busy,
  input wire logic [3:0] device_select_lines,
  input wire logic [7:0] host_data_lines, view_code,
  input wire logic [2:0] character_count_select,
  input wire logic [6:0] view_addr, cursor_pos, char_total
);
  timeunit 1ns;
  timeprecision 1ns;
  // Length of the current busy spell
  int cnt;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      cnt <= 0;
    end else begin
      cnt <= busy ? cnt + 1 : 0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_oe; busy_flag_oe == (&device_select_lines && read_write && strobe); endproperty
  property p_flag; busy_flag_oe |-> busy_flag_line == busy; endproperty
  property p_start; $rose(busy) |-> $past(strobe) && !$past(strobe, 2); endproperty
  property p_len; $fell(busy) |-> (cnt >= 1000 && cnt <= 2000) || (cnt >= 40000 && cnt <= 41000); endproperty
  property p_max; cnt <= 41000; endproperty
  property p_keep; busy && $past(busy) |-> $stable(cursor_pos) && $stable(cursor_visible); endproperty
  property p_cause; $changed(cursor_pos) || $changed(cursor_visible) |-> $rose(busy); endproperty
  property p_range; cursor_pos < char_total; endproperty
  // Copies lag the pins by one edge, so the edge right after a release is skipped
  property p_lines; $past(nrst) |-> two_lines == $past(line_count_select) &&
    tall_font == $past(font_height_select) && wide_cursor == $past(cursor_shape_select); endproperty
  a_oe: assert property (p_oe) else $error("flag enable wrong");
  a_flag: assert property (p_flag) else $error("flag value wrong");
  a_start: assert property (p_start) else $error("busy without strobe");
  a_len: assert property (p_len) else $error("busy length wrong");
  a_max: assert property (p_max) else $error("busy too long");
  a_keep: assert property (p_keep) else $error("state moved while busy");
  a_cause: assert property (p_cause) else $error("state moved without start");
  a_range: assert property (p_range) else $error("cursor out of range");
  a_lines: assert property (p_lines) else $error("line mode wrong");
  c_clear: cover property ($fell(busy) && cnt > 30000);
  c_read: cover property (busy_flag_oe && busy_flag_line);
  c_char: cover property ($rose(busy) && register_select_line);
endmodule // cdh_mon
bind cdh_top cdh_mon cdh_mon_i (.*);

// ### dv/cdh_host.sv
// Host processor model on the strobed parallel port
module cdh_host (
  input wire logic ref_clk, busy_flag_line, busy_flag_oe,
  output logic [3:0] sel,
  output logic rs, rw, stb,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sel, rs, rw, stb, data} = {4'h0, 1'b0, 1'b1, 1'b0, 8'h00};
  end
  // Write: fall latches, rise starts; hold sets the pace
  task automatic wr(input logic r, input logic [7:0] d, input logic [3:0] s, input int hold);
    @(posedge ref_clk) {sel, rs, rw, stb, data} <= {s, r, 1'b0, 1'b1, d};
    repeat (hold) @(posedge ref_clk);
    stb <= 1'b0;
    repeat (hold) @(posedge ref_clk);
    stb <= 1'b1;
    repeat (hold) @(posedge ref_clk);
    {sel, rw, stb, data} <= {4'h0, 1'b1, 1'b0, ~d}; // Released bus shows no stale data
  endtask
  // Poll the flag until ready, bounded
  task automatic wait_ready(output int n);
    @(posedge ref_clk) {sel, stb} <= {4'hF, 1'b1};
    n = 0;
    @(negedge ref_clk);
    while ((busy_flag_oe !== 1'b1 || busy_flag_line !== 1'b0) && n < 50000) begin
      n++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk) {sel, stb} <= {4'h0, 1'b0};
  endtask
endmodule // cdh_host

// ### dv/tb.sv
// Self-checking bench for the display host command interpreter
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t got %h want %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, nrst = 0, rs, rw, stb, fl, oe, vis, two, tall, wide, busy, font, shape;
  logic [3:0] sel;
  logic [7:0] data, code;
  logic [6:0] addr = 0, pos_o, tot_o;
  int mismatches, compares, cyc, n, pos, vm = 1, mem[80];
  logic lines = 1'b1; // Line count pin, changed only under reset
  logic [2:0] cnt_sel = 3'h3; // Character count code, changed only under reset
  int mtot = 24, mtwo = 1; // Model setup: digits and line mode
  int tots[8] = '{4, 8, 16, 24, 32, 40, 64, 80}; // Digits per count code
  always #25 ref_clk = ~ref_clk;
  cdh_host cdh_host_i (.ref_clk(ref_clk), .busy_flag_line(fl), .busy_flag_oe(oe), .sel(sel), .rs(rs),
    .rw(rw), .stb(stb), .data(data));
  cdh_top cdh_top_i (.ref_clk(ref_clk), .nrst(nrst), .device_select_lines(sel), .register_select_line(rs),
    .read_write(rw), .strobe(stb), .host_data_lines(data), .busy_flag_line(fl), .busy_flag_oe(oe),
    .character_count_select(cnt_sel), .line_count_select(lines), .font_height_select(font),
    .cursor_shape_select(shape), .view_addr(addr), .view_code(code), .cursor_pos(pos_o),
    .cursor_visible(vis), .two_lines(two), .tall_font(tall), .wide_cursor(wide), .char_total(tot_o), .busy(busy));
  // Reference model over the configured digit count and line mode
  function void mdl(input int r, input int d);
    if (r) begin mem[pos] = d; pos = (pos + 1) % mtot; end
    else if (d == 1) begin foreach (mem[i]) mem[i] = 32; pos = 0; end
    else if (d == 2) pos = 0;
    else if (d == 4 || d == 5) vm = (d == 4);
    else if (d >= 128) pos = !mtwo ? (d & 127) : (d & 64) ? mtot / 2 + (d & 63) : (d & 63);
  endfunction
  task automatic check_all();
    `CHK(pos_o, pos[6:0])
    `CHK(vis, vm[0])
    for (int i = 0; i < 80; i++) begin
      @(posedge ref_clk) addr <= i[6:0];
      @(posedge ref_clk);
      @(negedge ref_clk) `CHK(code, mem[i][7:0])
    end
  endtask
  task automatic op(input int r, input int d);
    int h;
    int t;
    h = $urandom_range(10, 14);
    cdh_host_i.wr(r[0], d[7:0], 4'hF, h);
    mdl(r, d);
    cdh_host_i.wait_ready(n);
    // The poll starts one hold after the strobe rise, so add it back
    t = n + h;
    if (r == 0 && d == 1) `CHK(t >= 40000 && t <= 41000, 1'b1)
    else `CHK(t >= 1000 && t <= 2000, 1'b1)
    check_all();
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin mismatches++; give_verdict(); end
  end
  initial begin
    void'($urandom(1867));
    font = $urandom % 2;
    shape = $urandom % 2;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    // Static copies settle one edge after the release
    @(posedge ref_clk);
    @(negedge ref_clk) `CHK({two, tall, wide, tot_o}, {mtwo[0], font, shape, mtot[6:0]})
    op(0, 1);
    repeat (3) op(1, $urandom_range(32, 126));
    op(0, 5);
    op(0, 4);
    cdh_host_i.wr(1'b1, 8'h41, 4'hF, 10);
    mdl(1, 65);
    cdh_host_i.wr(1'b1, 8'h42, 4'hF, 10);
    cdh_host_i.wait_ready(n);
    check_all();
    cdh_host_i.wr(1'b1, 8'h43, 4'hE, 10);
    @(negedge ref_clk) `CHK(busy, 1'b0)
    op(0, 8'hCB);
    op(1, 8'h44);
    op(0, 8'h85);
    op(0, 2);
    op(0, 8'h37);
    // Mid-run reset into one-line mode with a random digit count
    @(posedge ref_clk) nrst <= 1'b0;
    lines <= 1'b0;
    cnt_sel <= 3'($urandom_range(0, 7));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    mtot = tots[cnt_sel];
    mtwo = 0;
    pos = 0;
    vm = 1;
    @(posedge ref_clk);
    @(negedge ref_clk) `CHK({two, tot_o, pos_o, vis}, {1'b0, mtot[6:0], 7'h00, 1'b1})
    op(0, 128 + $urandom_range(0, mtot - 1));
    op(0, 128 + mtot - 1);
    op(1, $urandom_range(32, 126));
    give_verdict();
  end
endmodule // tb
